//--- rtl/alarm_channel.v
// one alarm channel: source select, sample history, compare
// assumes: words on this clock, stable at the tick; trip_out is combinational
`include "alarm_monitor_defs.vh"
`default_nettype none

module alarm_channel #(
    parameter PTR_W = 8
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        reset_n_in,
    input  wire        tick_in,
    // settings
    input  wire [3:0]  src_sel_in,
    input  wire        dynamic_in,
    input  wire        above_in,
    input  wire        filter_in,
    input  wire [7:0]  count_in,
    input  wire [15:0] magnitude_in,
    // data sources
    input  wire [15:0] coarse_rate_word_in,
    input  wire [15:0] filtered_rate_word_in,
    input  wire [15:0] temperature_word_in,
    input  wire [15:0] diagnostic_status_word_in,
    // result
    output wire        trip_out
);
    reg  [15:0]    hist_mem [0:(1<<PTR_W)-1];
    reg  [PTR_W-1:0] wr_ptr_reg;
    reg  [PTR_W:0] fill_reg;
    reg  [3:0]     src_last_reg;
    reg            mode_last_reg;
    reg  [15:0]    src_word;
    wire           is_signed;
    wire [7:0]     span;
    wire [15:0]    old_word;
    wire [16:0]    cur_ext;
    wire [16:0]    old_ext;
    wire [16:0]    mag_ext;
    wire [16:0]    delta;
    wire           ready;
    wire           hit_static;
    wire           hit_dynamic;

    // sign-extend when the source is twos complement
    function [16:0] ext17;
        input [15:0] w;
        input        s;
        begin
            ext17 = {s & w[15], w};
        end
    endfunction

    // polarity compare on 17-bit signed values
    function hit;
        input [16:0] v;
        input [16:0] m;
        input        above;
        begin
            hit = above ? ($signed(v) > $signed(m)) : ($signed(v) < $signed(m));
        end
    endfunction

    // ======================================================================
    // source mux; filtering only touches the rate word
    always @* begin
        case (src_sel_in)
            `SRC_RATE: src_word = filter_in ? filtered_rate_word_in
                                            : coarse_rate_word_in;
            `SRC_TEMP: src_word = temperature_word_in;
            `SRC_DIAG: src_word = diagnostic_status_word_in;
            default:   src_word = 16'h0000;
        endcase
    end

    // diag word is a bit field, compared unsigned; the rest are signed
    assign is_signed = (src_sel_in != `SRC_DIAG);
    assign span      = (count_in <= 8'h01) ? 8'h01 : count_in;
    assign old_word  = hist_mem[wr_ptr_reg - span[PTR_W-1:0]];
    assign cur_ext   = ext17(src_word, is_signed);
    assign old_ext   = ext17(old_word, is_signed);
    assign mag_ext   = ext17(magnitude_in, is_signed);
    assign delta     = cur_ext - old_ext;
    assign ready     = (fill_reg >= {1'b0, span});
    assign hit_static  = hit(cur_ext, mag_ext, above_in);
    assign hit_dynamic = ready & hit(delta, mag_ext, above_in);

    // disabled or unknown source never trips
    assign trip_out = (src_sel_in != `SRC_DISABLE && src_sel_in <= `SRC_DIAG) &
                      (dynamic_in ? hit_dynamic : hit_static);

    // ======================================================================
    // history; a source or mode change restarts the fill so, after the tick that sees the change,
    // no word of another format forms a delta (that tick still compares against the old history)
    always @(posedge clk_in) begin
        if (tick_in) begin
            hist_mem[wr_ptr_reg] <= src_word;
        end
    end

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            wr_ptr_reg    <= {PTR_W{1'b0}};
            fill_reg      <= {(PTR_W+1){1'b0}};
            src_last_reg  <= `SRC_DISABLE;
            mode_last_reg <= 1'b0;
        end else if (tick_in) begin
            wr_ptr_reg    <= wr_ptr_reg + 1'b1;
            src_last_reg  <= src_sel_in;
            mode_last_reg <= dynamic_in;
            if (src_sel_in != src_last_reg || dynamic_in != mode_last_reg) begin
                fill_reg <= {{PTR_W{1'b0}}, 1'b1};
            end else if (fill_reg != {1'b1, {PTR_W{1'b0}}}) begin
                fill_reg <= fill_reg + 1'b1;
            end
        end
    end
endmodule // alarm_channel

`default_nettype wire

//--- rtl/alarm_monitor_defs.vh
// constants for the dual channel alarm monitor
// assumes: 20 MHz clock, byte-wide register port
//
// Summary of operation
// - two independent channels, own settings each except the shared filter bit
// - alarm 2 source code selects off/rate/temp/diag
// - alarm 1 source uses same encoding
// - mode bits: 1 dynamic, 0 static
// - static compares source word with magnitude
// - polarity bits: 1 above, 0 below
// - dynamic compares change over sample count
// - sample count 0 or 1 means one
// - magnitude uses the selected source format
// - filter bit selects filtered coarse rate only
// - output enable drives indicator onto line
// - indicator polarity: 1 high, 0 low
// - line select: 1 second, 0 first
// - alarm flags appear as status bits 9:8
// - 16-bit registers written as two bytes
// - channels sample at internal sample rate, or on pin rising edges when the period is 0
`ifndef ALARM_MONITOR_DEFS_VH
`define ALARM_MONITOR_DEFS_VH

// ==========================================================================
// register byte addresses (lower byte, upper byte at +1)
`define ADDR_ALARM1_MAGNITUDE    8'h10
`define ADDR_ALARM2_MAGNITUDE    8'h12
`define ADDR_ALARM1_SAMPLE_COUNT 8'h14
`define ADDR_ALARM2_SAMPLE_COUNT 8'h16
`define ADDR_ALARM_CONFIGURATION 8'h18
`define REG_RESET_VALUE          16'h0000
`define CNT_RESET_VALUE          8'h00

// ==========================================================================
// configuration field positions
`define CFG_SRC2_HI   15
`define CFG_SRC2_LO   12
`define CFG_SRC1_HI   11
`define CFG_SRC1_LO   8
`define CFG_MODE2     7
`define CFG_MODE1     6
`define CFG_POL2      5
`define CFG_POL1      4
`define CFG_FILTER    3
`define CFG_OUT_EN    2
`define CFG_OUT_POL   1
`define CFG_OUT_SEL   0
`define SMPL_CNT_HI   7

// ==========================================================================
// source codes
`define SRC_DISABLE   4'h0
`define SRC_RATE      4'h1
`define SRC_TEMP      4'h2
`define SRC_DIAG      4'h3

// ==========================================================================
// status flag positions
`define DIAG_ALARM1_BIT 8
`define DIAG_ALARM2_BIT 9

// ==========================================================================
// timing: internal sample clock base and system clock
`define CLK_FREQ_HZ      20000000
`define BASE_FREQ_HZ     32768
`define BASE_TICK_CYCLES (`CLK_FREQ_HZ / `BASE_FREQ_HZ)

`endif

//--- rtl/dual_channel_alarm_monitor.v
// dual channel alarm monitor: registers, two channels, indicator line
// assumes: byte strobes and sensor words on this clock; line arbitration outside
`include "alarm_monitor_defs.vh"
`default_nettype none

module dual_channel_alarm_monitor #(
    parameter BASE_CYCLES = `BASE_TICK_CYCLES,
    parameter HIST_PTR_W  = 8
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        reset_n_in,
    // byte register port
    input  wire [7:0]  reg_addr_in,
    input  wire        reg_wr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    output reg         reg_rvalid_out,
    // sample rate control
    input  wire [15:0] sample_period_setting_in,
    input  wire        ext_sample_clock_in,
    // sensor data words
    input  wire [15:0] coarse_rate_word_in,
    input  wire [15:0] filtered_rate_word_in,
    input  wire [15:0] temperature_word_in,
    input  wire [15:0] diagnostic_status_word_in,
    // alarm status
    output reg  [1:0]  alarm_flags_out,
    output reg         sample_tick_out,
    // general-purpose lines
    output reg         first_general_line_out,
    output reg         first_general_line_oe_out,
    output reg         second_general_line_out,
    output reg         second_general_line_oe_out
);
    // ======================================================================
    // declarations
    reg  [15:0] alarm1_magnitude_reg;
    reg  [15:0] alarm2_magnitude_reg;
    reg  [7:0]  alarm1_sample_count_reg;
    reg  [7:0]  alarm2_sample_count_reg;
    reg  [15:0] alarm_configuration_reg;
    reg  [7:0]  rdata_next;
    reg  [1:0]  flags_next;
    reg         indicator_next;
    wire        tick;
    wire        trip1;
    wire        trip2;
    wire        any_alarm;
    wire [7:0]  word_addr;
    wire        upper_byte;

    // ======================================================================
    // byte merge into a 16-bit register
    function [15:0] merge_byte;
        input [15:0] old_value;
        input [7:0]  data;
        input        upper;
        begin
            merge_byte = upper ? {data, old_value[7:0]}
                               : {old_value[15:8], data};
        end
    endfunction

    // select a byte of a 16-bit register for readback
    function [7:0] pick_byte;
        input [15:0] value;
        input        upper;
        begin
            pick_byte = upper ? value[15:8] : value[7:0];
        end
    endfunction

    // the low address bit selects the byte of a register
    assign word_addr  = {reg_addr_in[7:1], 1'b0};
    assign upper_byte = reg_addr_in[0];

    // ======================================================================
    // register writes, one byte per strobe
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            alarm1_magnitude_reg    <= `REG_RESET_VALUE;
            alarm2_magnitude_reg    <= `REG_RESET_VALUE;
            alarm1_sample_count_reg <= `CNT_RESET_VALUE;
            alarm2_sample_count_reg <= `CNT_RESET_VALUE;
            alarm_configuration_reg <= `REG_RESET_VALUE;
        end else if (reg_wr_in) begin
            case (word_addr)
                `ADDR_ALARM1_MAGNITUDE: begin
                    alarm1_magnitude_reg <= merge_byte(alarm1_magnitude_reg,
                                                       reg_wdata_in, upper_byte);
                end
                `ADDR_ALARM2_MAGNITUDE: begin
                    alarm2_magnitude_reg <= merge_byte(alarm2_magnitude_reg,
                                                       reg_wdata_in, upper_byte);
                end
                `ADDR_ALARM1_SAMPLE_COUNT: begin
                    // upper byte unused, writes to it are dropped
                    if (!upper_byte) begin
                        alarm1_sample_count_reg <= reg_wdata_in;
                    end
                end
                `ADDR_ALARM2_SAMPLE_COUNT: begin
                    if (!upper_byte) begin
                        alarm2_sample_count_reg <= reg_wdata_in;
                    end
                end
                `ADDR_ALARM_CONFIGURATION: begin
                    alarm_configuration_reg <= merge_byte(alarm_configuration_reg,
                                                          reg_wdata_in, upper_byte);
                end
                default: begin
                end
            endcase
        end
    end

    // ======================================================================
    // readback mux; unmapped bytes read as zero
    always @* begin
        case (word_addr)
            `ADDR_ALARM1_MAGNITUDE:
                rdata_next = pick_byte(alarm1_magnitude_reg, upper_byte);
            `ADDR_ALARM2_MAGNITUDE:
                rdata_next = pick_byte(alarm2_magnitude_reg, upper_byte);
            `ADDR_ALARM1_SAMPLE_COUNT:
                rdata_next = upper_byte ? 8'h00 : alarm1_sample_count_reg;
            `ADDR_ALARM2_SAMPLE_COUNT:
                rdata_next = upper_byte ? 8'h00 : alarm2_sample_count_reg;
            `ADDR_ALARM_CONFIGURATION:
                rdata_next = pick_byte(alarm_configuration_reg, upper_byte);
            default:
                rdata_next = 8'h00;
        endcase
    end

    // read data registered, valid one cycle after the strobe
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= rdata_next;
            end
        end
    end

    // ======================================================================
    // sample rate: internal divider, or pin rising edges when the period is 0
    sample_tick_gen #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_tick (
        .clk_in       (clk_in),
        .reset_n_in   (reset_n_in),
        .period_in    (sample_period_setting_in),
        .ext_clock_in (ext_sample_clock_in),
        .tick_out     (tick)
    );

    // ======================================================================
    // two channels, each with its own slice of the settings; the filter bit is shared
    alarm_channel #(
        .PTR_W (HIST_PTR_W)
    ) u_alarm1 (
        .clk_in                    (clk_in),
        .reset_n_in                (reset_n_in),
        .tick_in                   (tick),
        .src_sel_in                (alarm_configuration_reg[`CFG_SRC1_HI:`CFG_SRC1_LO]),
        .dynamic_in                (alarm_configuration_reg[`CFG_MODE1]),
        .above_in                  (alarm_configuration_reg[`CFG_POL1]),
        .filter_in                 (alarm_configuration_reg[`CFG_FILTER]),
        .count_in                  (alarm1_sample_count_reg),
        .magnitude_in              (alarm1_magnitude_reg),
        .coarse_rate_word_in       (coarse_rate_word_in),
        .filtered_rate_word_in     (filtered_rate_word_in),
        .temperature_word_in       (temperature_word_in),
        .diagnostic_status_word_in (diagnostic_status_word_in),
        .trip_out                  (trip1)
    );

    alarm_channel #(
        .PTR_W (HIST_PTR_W)
    ) u_alarm2 (
        .clk_in                    (clk_in),
        .reset_n_in                (reset_n_in),
        .tick_in                   (tick),
        .src_sel_in                (alarm_configuration_reg[`CFG_SRC2_HI:`CFG_SRC2_LO]),
        .dynamic_in                (alarm_configuration_reg[`CFG_MODE2]),
        .above_in                  (alarm_configuration_reg[`CFG_POL2]),
        .filter_in                 (alarm_configuration_reg[`CFG_FILTER]),
        .count_in                  (alarm2_sample_count_reg),
        .magnitude_in              (alarm2_magnitude_reg),
        .coarse_rate_word_in       (coarse_rate_word_in),
        .filtered_rate_word_in     (filtered_rate_word_in),
        .temperature_word_in       (temperature_word_in),
        .diagnostic_status_word_in (diagnostic_status_word_in),
        .trip_out                  (trip2)
    );

    // ======================================================================
    // flag and indicator next values
    assign any_alarm = trip1 | trip2;

    always @* begin
        flags_next = 2'b00;
        flags_next[`DIAG_ALARM1_BIT - 8] = trip1;
        flags_next[`DIAG_ALARM2_BIT - 8] = trip2;
        // polarity applied here so an idle line rests at its inactive level
        indicator_next = alarm_configuration_reg[`CFG_OUT_POL] ? any_alarm
                                                               : ~any_alarm;
    end

    // ======================================================================
    // flags and indicator change only on a sample; the line enable follows
    // the configuration on the next clock, without waiting for a sample, so a disabled line is released promptly
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            alarm_flags_out            <= 2'b00;
            sample_tick_out            <= 1'b0;
            first_general_line_out     <= 1'b0;
            first_general_line_oe_out  <= 1'b0;
            second_general_line_out    <= 1'b0;
            second_general_line_oe_out <= 1'b0;
        end else begin
            sample_tick_out <= tick;
            if (tick) begin
                alarm_flags_out         <= flags_next;
                first_general_line_out  <= indicator_next;
                second_general_line_out <= indicator_next;
            end
            first_general_line_oe_out  <= alarm_configuration_reg[`CFG_OUT_EN] &
                                          ~alarm_configuration_reg[`CFG_OUT_SEL];
            second_general_line_oe_out <= alarm_configuration_reg[`CFG_OUT_EN] &
                                          alarm_configuration_reg[`CFG_OUT_SEL];
        end
    end
endmodule // dual_channel_alarm_monitor

`default_nettype wire

//--- rtl/sample_tick_gen.v
// sample-rate enable generator
// assumes: period on this clock; the pin is asynchronous
`include "alarm_monitor_defs.vh"
`default_nettype none

module sample_tick_gen #(
    parameter BASE_CYCLES = `BASE_TICK_CYCLES
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        reset_n_in,
    // rate control
    input  wire [15:0] period_in,
    input  wire        ext_clock_in,
    // sample enable
    output reg         tick_out
);
    reg  [15:0] base_cnt_reg;
    reg  [15:0] period_cnt_reg;
    reg         ext_meta_reg;
    reg         ext_sync_reg;
    reg         ext_prev_reg;
    wire        base_tick;

    assign base_tick = (base_cnt_reg == BASE_CYCLES[15:0] - 16'h0001);

    // ======================================================================
    // base divider and period counter, fs = base / (period + 1)
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            base_cnt_reg   <= 16'h0000;
            period_cnt_reg <= 16'h0000;
            ext_meta_reg   <= 1'b0;
            ext_sync_reg   <= 1'b0;
            ext_prev_reg   <= 1'b0;
            tick_out       <= 1'b0;
        end else begin
            ext_meta_reg <= ext_clock_in;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
            base_cnt_reg <= base_tick ? 16'h0000 : base_cnt_reg + 16'h0001;
            tick_out     <= 1'b0;
            if (period_in == 16'h0000) begin
                // internal clock off: rising edge of the pin paces samples
                period_cnt_reg <= 16'h0000;
                tick_out       <= ext_sync_reg & ~ext_prev_reg;
            end else if (base_tick) begin
                if (period_cnt_reg >= period_in) begin
                    period_cnt_reg <= 16'h0000;
                    tick_out       <= 1'b1;
                end else begin
                    period_cnt_reg <= period_cnt_reg + 16'h0001;
                end
            end
        end
    end
endmodule // sample_tick_gen

`default_nettype wire

//--- tb/alarm_monitor_checker.sv
// port checker for the dual channel alarm monitor
// assumes: bound to the top module, one clock, synchronous active-low reset
`default_nettype none
// ==========
// checker
module alarm_monitor_checker #(
    parameter int BASE_CYCLES = 2
) (
    // clock and reset
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    // register port
    input wire logic [7:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        reg_rvalid_out,
    // alarm side
    input wire logic [15:0] sample_period_setting_in,
    input wire logic [1:0]  alarm_flags_out,
    input wire logic        sample_tick_out,
    input wire logic        first_general_line_out,
    input wire logic        first_general_line_oe_out,
    input wire logic        second_general_line_out,
    input wire logic        second_general_line_oe_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] cfg_reg;
    logic [31:0] gap_reg;
    logic        seen_reg;
    // config shadow, cycles since last sample
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cfg_reg  <= 16'h0000;
            gap_reg  <= 32'h0;
            seen_reg <= 1'b0;
        end else begin
            if (reg_wr_in && reg_addr_in == 8'h18) cfg_reg[7:0] <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == 8'h19) cfg_reg[15:8] <= reg_wdata_in;
            gap_reg <= sample_tick_out ? 32'h1 : gap_reg + 32'h1;
            if (sample_tick_out) seen_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // ==========
    // properties
    read_latency_a: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read answer missing");
    cfg_readback_a: assert property (
        reg_rd_in && reg_addr_in[7:1] == 7'h0c && !reg_wr_in |=> reg_rdata_out ==
        ($past(reg_addr_in[0]) ? cfg_reg[15:8] : cfg_reg[7:0])) else $error("config readback");
    count_upper_a: assert property (
        reg_rd_in && (reg_addr_in == 8'h15 || reg_addr_in == 8'h17) |=> reg_rdata_out == 8'h00)
        else $error("count upper byte not zero");
    unmapped_read_a: assert property (reg_rd_in && reg_addr_in > 8'h19 |=>
        reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    oe_follow_a: assert property (reg_wr_in && reg_addr_in == 8'h18 |=> ##1
        {second_general_line_oe_out, first_general_line_oe_out} ==
        {$past(reg_wdata_in[2] & reg_wdata_in[0], 2), $past(reg_wdata_in[2] & ~reg_wdata_in[0], 2)})
        else $error("line enable wrong");
    // flags may only move on the sample pulse
    flags_hold_a: assert property (!sample_tick_out |-> $stable(alarm_flags_out))
        else $error("flags moved off sample");
    indicator_lvl_a: assert property (
        sample_tick_out && $stable(cfg_reg) |-> first_general_line_out ==
        (cfg_reg[1] ? |alarm_flags_out : ~|alarm_flags_out) &&
        second_general_line_out == first_general_line_out) else $error("indicator level");
    disabled_src_a: assert property (
        sample_tick_out && $stable(cfg_reg) && cfg_reg[15:12] == 4'h0 |-> !alarm_flags_out[1])
        else $error("disabled alarm tripped");
    tick_period_a: assert property (
        sample_tick_out && seen_reg && sample_period_setting_in != 16'h0 |->
        gap_reg == BASE_CYCLES * (sample_period_setting_in + 32'h1)) else $error("sample gap");
    cover property (sample_tick_out && alarm_flags_out == 2'b11);
    cover property (sample_tick_out && alarm_flags_out == 2'b10);
    cover property (reg_rd_in && reg_addr_in == 8'h1a);
endmodule // alarm_monitor_checker
`default_nettype wire

//--- tb/host_model.sv
// host model: byte register writes and reads, driven on the falling edge
// assumes: the block answers a read one clock later with a valid pulse
`default_nettype none
// ==========
// register host
module host_model (
    // clock and answer
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    // requests
    output var  logic [7:0] addr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       wr_out,
    output var  logic       rd_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle port at time zero
    initial begin
        {addr_out, wdata_out, wr_out, rd_out} = 18'h0;
    end
    // one byte; data inverted after release
    task automatic wr8(input logic [7:0] a, d);
        @(negedge clk_in);
        {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
        @(negedge clk_in);
        {wdata_out, wr_out} = {~d, 1'b0};
    endtask
    // lower byte at the even address, upper at the next
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr8(a, d[7:0]);
        wr8(a + 8'h1, d[15:8]);
    endtask
    // byte read, taken only with the valid pulse
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        {addr_out, rd_out} = {a, 1'b1};
        @(negedge clk_in);
        rd_out = 1'b0;
        d = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
    endtask
endmodule // host_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the dual channel alarm monitor
// assumes: host model and checker compiled first; short sample period
`default_nettype none
// ==========
// bench top
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [15:0] cfg, m1, m2; logic [1:0] f; logic l;} row_t;
    // static rows: config, magnitudes, expected flags and line level
    row_t rows [6] = '{{16'h1126, 16'h0200, 16'h0080, 2'b11, 1'b1},
        {16'h112e, 16'h0200, 16'h0080, 2'b01, 1'b1}, {16'h2235, 16'h0050, 16'h004f, 2'b10, 1'b0},
        {16'h3306, 16'h8001, 16'h7fff, 2'b01, 1'b1}, {16'h0436, 16'h0000, 16'h0000, 2'b00, 1'b0},
        {16'h223e, 16'h004f, 16'h004f, 2'b11, 1'b1}};
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic        reg_wr_in, reg_rd_in, reg_rvalid_out, sample_tick_out, l1, e1, l2, e2;
    logic [15:0] rate_w = 16'h0100;
    logic [15:0] c;
    logic [5:0]  x;
    logic [1:0]  alarm_flags_out;
    int          checks = 0;
    int          n_mismatch = 0;
    host_model u_host (.clk_in(clk_in), .rdata_in(reg_rdata_out), .rvalid_in(reg_rvalid_out),
        .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in));
    // tick every 2 * (1 + 1) clocks keeps the run short
    dual_channel_alarm_monitor #(.BASE_CYCLES(2)) u_dut (.*, .sample_period_setting_in(16'h0001),
        .ext_sample_clock_in(1'b0), .coarse_rate_word_in(rate_w),
        .filtered_rate_word_in(~rate_w), .temperature_word_in(16'h0050),
        .diagnostic_status_word_in(16'h8000), .first_general_line_out(l1),
        .first_general_line_oe_out(e1), .second_general_line_out(l2),
        .second_general_line_oe_out(e2));
    always #25 clk_in = ~clk_in;
    // count one comparison, report a mismatch
    task automatic chk(input logic [15:0] g, e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, e);
        logic [7:0] d;
        u_host.rd8(a, d);
        chk({8'h0, d}, {8'h0, e});
    endtask
    // bounded wait for the next sample pulse
    task automatic wait_tick;
        int i;
        @(negedge clk_in);
        for (i = 0; i < 50 && sample_tick_out !== 1'b1; i++) @(negedge clk_in);
        if (sample_tick_out !== 1'b1) begin
            n_mismatch++;
            end_of_test;
        end
    endtask
    // ramp the rate word by a fixed step per sample, then look at alarm 1
    task automatic dyn(input logic [7:0] n, input logic [15:0] st, m, input logic e);
        u_host.wr8(8'h14, n);
        u_host.wr16(8'h10, m);
        repeat (6) begin
            wait_tick;
            rate_w = rate_w + st;
        end
        wait_tick;
        chk({15'h0, alarm_flags_out[0]}, {15'h0, e});
    endtask
    task automatic end_of_test;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        reset_n_in = 1'b1;
        // reset values, unmapped byte included
        for (int a = 8'h10; a <= 8'h1a; a++) rchk(8'(a), 8'h00);
        // both bytes of every register; upper count bytes stay zero
        for (int a = 8'h10; a <= 8'h18; a += 2) begin
            u_host.wr16(8'(a), {8'(a), 8'h3c});
            rchk(8'(a), 8'h3c);
            rchk(8'(a + 1), (a == 8'h14 || a == 8'h16) ? 8'h00 : 8'(a));
        end
        foreach (rows[i]) begin
            c = rows[i].cfg;
            u_host.wr16(8'h10, rows[i].m1);
            u_host.wr16(8'h12, rows[i].m2);
            u_host.wr16(8'h18, c);
            wait_tick;
            wait_tick;
            x = {rows[i].f, {2{rows[i].l}}, c[2] & c[0], c[2] & ~c[0]};
            chk({10'h0, alarm_flags_out, l2, l1, e2, e1}, {10'h0, x});
        end
        // dynamic alarm 1 on the raw rate word, count 0 means one sample
        u_host.wr16(8'h18, 16'h0156);
        dyn(8'h00, 16'h4, 16'h3, 1'b1);
        dyn(8'h03, 16'h4, 16'h10, 1'b0);
        dyn(8'h03, 16'h8, 16'h10, 1'b1);
        // reset in mid-run while alarm 1 is active
        reset_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        reset_n_in = 1'b1;
        chk({12'h0, alarm_flags_out, e2, e1}, 16'h0);
        rchk(8'h18, 8'h00);
        end_of_test;
    end
endmodule // tb_top
bind dual_channel_alarm_monitor alarm_monitor_checker #(.BASE_CYCLES(BASE_CYCLES)) u_chk (.*);
`default_nettype wire
